/* rtl/operating_mode_select.v */
// Overview of operation
// - Straps latched into mode bits at reset release
// - Decode six user modes from three straps
// - Mid one, low zero codes are factory test
// - Each mode selects default map and bus
// - Debug active at once only in special single
// - Mode bits readable, changes only restricted
// - Protect bits in normal, relax in special
// - Both interrupt inputs inhibited at reset
// - Bus clock stretch set by reset, user modes
// - Mode pins pull down in reset, float after
// - Normal single-chip mode register writable once
// - Single-chip port E enables reset, ineffective
`timescale 1ns/1ps
`default_nettype none
`include "opmode_consts.vh"
module operating_mode_select (
  // Clock and reset
  input wire mclk_in,
  input wire rst_in,
  // Mode straps
  input wire mode_strap_high_in,
  input wire mode_strap_mid_in,
  input wire mode_strap_low_in,
  // Register port
  input wire [3:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  // Serial debug activation command
  input wire debug_cmd_in,
  // Mode status
  output reg [2:0] mode_out,
  output reg special_mode_out,
  output reg factory_test_out,
  output reg background_debug_active_out,
  output reg [7:0] memmap_out,
  output reg expanded_narrow_out,
  output reg expanded_wide_out,
  output reg internal_visibility_out,
  // Port E control
  output reg queue_track_enable_out,
  output reg low_strobe_pin_enable_out,
  output reg read_write_pin_enable_out,
  output reg bus_clock_stretch_out,
  output reg maskable_int_enable_out,
  output reg nonmaskable_interrupt_pin_enable_out,
  output reg int_pins_pullup_out,
  output reg mode_pins_pulldown_out
);
  wire [2:0] code;
  wire release_pulse;
  wire dec_special;
  wire dec_single;
  wire dec_narrow;
  wire dec_wide;
  wire dec_test;
  wire [7:0] dec_map;
  reg [2:0] mode_reg;
  reg vis_reg;
  reg mode_written_reg;
  reg pipe_status_enable_reg;
  reg low_strobe_enable_reg;
  reg read_write_enable_reg;
  reg bus_clock_stretch_reg;
  reg int_ctrl_m_reg;
  reg int_ctrl_x_reg;
  reg debug_active_reg;
  reg [7:0] rdata_next;
  wire [2:0] wr_mode;
  wire mode_wr;
  wire pea_wr;
  // Reset images, named so single bits can be picked out of them
  localparam [7:0] RST_BUS = `RST_BUS_CTRL;
  localparam [7:0] RST_INT = `RST_INT_CTRL;

  strap_capture u_cap (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .mode_strap_high_in(mode_strap_high_in),
    .mode_strap_mid_in(mode_strap_mid_in),
    .mode_strap_low_in(mode_strap_low_in),
    .code_out(code),
    .release_out(release_pulse)
  );

  mode_decode u_dec (
    .code_in(mode_reg),
    .special_out(dec_special),
    .single_out(dec_single),
    .narrow_out(dec_narrow),
    .wide_out(dec_wide),
    .factory_test_out(dec_test),
    .memmap_out(dec_map)
  );

  assign wr_mode = {wdata_in[`MODE_HIGH_BIT], wdata_in[`MODE_MID_BIT],
                    wdata_in[`MODE_LOW_BIT]};
  assign mode_wr = wr_in && (addr_in == `OFS_MODE);
  assign pea_wr = wr_in && (addr_in == `OFS_PORT_E_ASSIGN);

  // Mode register and one-time write
  always @(posedge mclk_in) begin
    if (rst_in) begin
      mode_reg <= 3'h0;
      vis_reg <= 1'b0;
      mode_written_reg <= 1'b0;
    end else if (release_pulse) begin
      mode_reg <= code;
      vis_reg <= 1'b0;
      mode_written_reg <= 1'b0;
    end else if (mode_wr) begin
      if (mode_reg == `MODE_NORMAL_SINGLE) begin
        // Only first write counts, only to normal expanded modes
        if (!mode_written_reg) begin
          mode_written_reg <= 1'b1;
          if (wr_mode == `MODE_NORMAL_NARROW ||
              wr_mode == `MODE_NORMAL_WIDE) begin
            mode_reg <= wr_mode;
          end
          vis_reg <= wdata_in[`MODE_VIS_BIT];
        end
      end else if (dec_special && !dec_test) begin
        // Special modes may switch among non-test codes
        if (!(wr_mode[1] & ~wr_mode[0])) begin
          mode_reg <= wr_mode;
        end
        vis_reg <= wdata_in[`MODE_VIS_BIT];
      end else if (!mode_written_reg) begin
        // Normal expanded and test modes: visibility written once (kept only in wide), mode locked
        mode_written_reg <= 1'b1;
        vis_reg <= wdata_in[`MODE_VIS_BIT] & dec_wide;
      end
    end
  end

  // Port E assignment and bus control
  always @(posedge mclk_in) begin
    if (rst_in) begin
      pipe_status_enable_reg <= 1'b0;
      low_strobe_enable_reg <= 1'b0;
      read_write_enable_reg <= 1'b0;
      bus_clock_stretch_reg <= RST_BUS[`BUS_STRETCH_BIT];
      int_ctrl_m_reg <= RST_INT[`INT_MASKABLE_BIT];
      int_ctrl_x_reg <= RST_INT[`INT_NONMASK_BIT];
    end else begin
      if (pea_wr && !dec_test) begin
        pipe_status_enable_reg <= wdata_in[`PEA_PIPE_BIT];
        low_strobe_enable_reg <= wdata_in[`PEA_LSTRB_BIT];
        read_write_enable_reg <= wdata_in[`PEA_RDW_BIT];
      end
      if (wr_in && addr_in == `OFS_BUS_CTRL) begin
        bus_clock_stretch_reg <= wdata_in[`BUS_STRETCH_BIT];
      end
      if (wr_in && addr_in == `OFS_INT_CTRL) begin
        int_ctrl_m_reg <= wdata_in[`INT_MASKABLE_BIT];
        int_ctrl_x_reg <= wdata_in[`INT_NONMASK_BIT];
      end
    end
  end

  // Background debug activation
  always @(posedge mclk_in) begin
    if (rst_in) begin
      debug_active_reg <= 1'b0;
    end else if (release_pulse) begin
      debug_active_reg <= (code == `MODE_SPECIAL_SINGLE);
    end else if (debug_cmd_in) begin
      debug_active_reg <= 1'b1;
    end
  end

  // Read data mux
  always @* begin
    rdata_next = 8'h00;
    if (addr_in == `OFS_MODE) begin
      rdata_next[`MODE_HIGH_BIT] = mode_reg[2];
      rdata_next[`MODE_MID_BIT] = mode_reg[1];
      rdata_next[`MODE_LOW_BIT] = mode_reg[0];
      rdata_next[`MODE_VIS_BIT] = vis_reg;
    end else if (addr_in == `OFS_PORT_E_ASSIGN) begin
      rdata_next[`PEA_PIPE_BIT] = pipe_status_enable_reg;
      rdata_next[`PEA_LSTRB_BIT] = low_strobe_enable_reg;
      rdata_next[`PEA_RDW_BIT] = read_write_enable_reg;
    end else if (addr_in == `OFS_BUS_CTRL) begin
      rdata_next[`BUS_STRETCH_BIT] = bus_clock_stretch_reg;
    end else if (addr_in == `OFS_INT_CTRL) begin
      rdata_next[`INT_MASKABLE_BIT] = int_ctrl_m_reg;
      rdata_next[`INT_NONMASK_BIT] = int_ctrl_x_reg;
    end else if (addr_in == `OFS_STATUS) begin
      rdata_next = {4'h0, dec_test, debug_active_reg, mode_written_reg,
                    dec_special};
    end else if (addr_in == `OFS_MEMMAP) begin
      rdata_next = dec_map;
    end
  end

  // Registered outputs
  always @(posedge mclk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
      mode_out <= 3'h0;
      special_mode_out <= 1'b0;
      factory_test_out <= 1'b0;
      background_debug_active_out <= 1'b0;
      memmap_out <= 8'h00;
      expanded_narrow_out <= 1'b0;
      expanded_wide_out <= 1'b0;
      internal_visibility_out <= 1'b0;
      queue_track_enable_out <= 1'b0;
      low_strobe_pin_enable_out <= 1'b0;
      read_write_pin_enable_out <= 1'b0;
      bus_clock_stretch_out <= 1'b1;
      maskable_int_enable_out <= 1'b0;
      nonmaskable_interrupt_pin_enable_out <= 1'b0;
      int_pins_pullup_out <= 1'b1;
      mode_pins_pulldown_out <= 1'b1;
    end else begin
      rdata_out <= rd_in ? rdata_next : 8'h00;
      mode_out <= mode_reg;
      special_mode_out <= dec_special;
      factory_test_out <= dec_test;
      background_debug_active_out <= debug_active_reg;
      memmap_out <= dec_map;
      expanded_narrow_out <= dec_narrow & !dec_test;
      expanded_wide_out <= dec_wide & !dec_test;
      internal_visibility_out <= vis_reg & (dec_wide | (dec_special &
                                 dec_narrow));
      // Enables have no pin effect in single-chip or test modes
      queue_track_enable_out <= pipe_status_enable_reg & !dec_single &
                                !dec_test;
      low_strobe_pin_enable_out <= low_strobe_enable_reg & dec_wide &
                                   !dec_test;
      read_write_pin_enable_out <= read_write_enable_reg & !dec_single &
                                   !dec_test;
      bus_clock_stretch_out <= bus_clock_stretch_reg;
      maskable_int_enable_out <= int_ctrl_m_reg;
      nonmaskable_interrupt_pin_enable_out <= int_ctrl_x_reg;
      int_pins_pullup_out <= ~int_ctrl_m_reg | ~int_ctrl_x_reg;
      mode_pins_pulldown_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* common/opmode_consts.vh */
`ifndef OPMODE_CONSTS_VH
`define OPMODE_CONSTS_VH

// Register offsets
`define OFS_MODE 4'h0
`define OFS_PORT_E_ASSIGN 4'h1
`define OFS_BUS_CTRL 4'h2
`define OFS_INT_CTRL 4'h3
`define OFS_STATUS 4'h4
`define OFS_MEMMAP 4'h5

// Mode register fields
`define MODE_HIGH_BIT 7
`define MODE_MID_BIT 6
`define MODE_LOW_BIT 5
`define MODE_VIS_BIT 3

// Port E assignment fields
`define PEA_PIPE_BIT 5
`define PEA_LSTRB_BIT 4
`define PEA_RDW_BIT 2

// Bus control fields
`define BUS_STRETCH_BIT 0

// Interrupt control fields
`define INT_MASKABLE_BIT 1
`define INT_NONMASK_BIT 0

// Mode codes {high, mid, low}
`define MODE_SPECIAL_SINGLE 3'h0
`define MODE_EMUL_NARROW 3'h1
`define MODE_EMUL_WIDE 3'h3
`define MODE_NORMAL_SINGLE 3'h4
`define MODE_NORMAL_NARROW 3'h5
`define MODE_NORMAL_WIDE 3'h7

// Reset values
`define RST_BUS_CTRL 8'h01
`define RST_INT_CTRL 8'h00
`define RST_PORT_E_ASSIGN 8'h00

// Default memory maps per mode
`define MAP_SINGLE 8'h01
`define MAP_NARROW 8'h02
`define MAP_WIDE 8'h03
`define MAP_TEST 8'h00

`endif

/* rtl/mode_decode.v */
`timescale 1ns/1ps
`default_nettype none
`include "opmode_consts.vh"
module mode_decode (
  // Mode code
  input wire [2:0] code_in,
  // Decoded class
  output wire special_out,
  output wire single_out,
  output wire narrow_out,
  output wire wide_out,
  output wire factory_test_out,
  output wire [7:0] memmap_out
);
  // Mid set with low clear is factory
  assign factory_test_out = code_in[1] & ~code_in[0];
  // High clear marks special and emulation modes
  assign special_out = ~code_in[2];
  assign single_out = ~code_in[1] & ~code_in[0];
  assign narrow_out = ~code_in[1] & code_in[0];
  assign wide_out = code_in[1] & code_in[0];
  // Per-mode default memory map
  assign memmap_out = factory_test_out ? `MAP_TEST :
                      single_out ? `MAP_SINGLE :
                      narrow_out ? `MAP_NARROW : `MAP_WIDE;
endmodule
`default_nettype wire

/* rtl/strap_capture.v */
`timescale 1ns/1ps
`default_nettype none
module strap_capture (
  // Clock and reset
  input wire mclk_in,
  input wire rst_in,
  // Straps
  input wire mode_strap_high_in,
  input wire mode_strap_mid_in,
  input wire mode_strap_low_in,
  // Captured code
  output reg [2:0] code_out,
  output reg release_out
);
  reg rst_d_reg;
  // Latch straps at the reset release edge
  always @(posedge mclk_in) begin
    rst_d_reg <= rst_in;
    release_out <= rst_d_reg & ~rst_in;
    if (rst_d_reg & ~rst_in) begin
      code_out <= {mode_strap_high_in, mode_strap_mid_in, mode_strap_low_in};
    end else if (rst_in) begin
      code_out <= 3'h0;
    end
  end
endmodule
`default_nettype wire

/* bench/operating_mode_select_props.sv */
`timescale 1ns/1ps
`default_nettype none
module operating_mode_select_props (
  // Clock, reset and requests
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [3:0] addr_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic debug_cmd_in,
  // Outputs watched
  input wire logic [7:0] rdata_out,
  input wire logic [2:0] mode_out,
  input wire logic special_mode_out,
  input wire logic factory_test_out,
  input wire logic background_debug_active_out,
  input wire logic queue_track_enable_out,
  input wire logic low_strobe_pin_enable_out,
  input wire logic read_write_pin_enable_out,
  input wire logic bus_clock_stretch_out,
  input wire logic maskable_int_enable_out,
  input wire logic int_pins_pullup_out,
  input wire logic mode_pins_pulldown_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  reset_defaults_a: assert property (disable iff (1'b0)
    rst_in ##1 rst_in |-> bus_clock_stretch_out && int_pins_pullup_out
      && mode_pins_pulldown_out && !maskable_int_enable_out)
    else $error("reset defaults wrong");
  pulldown_release_a: assert property (
    !rst_in [*5] |-> !mode_pins_pulldown_out)
    else $error("pull-down kept after reset");
  test_decode_a: assert property (
    !rst_in [*5] |-> factory_test_out == (mode_out[1:0] == 2'b10))
    else $error("test decode wrong");
  special_decode_a: assert property (
    !rst_in [*5] |-> special_mode_out == !mode_out[2])
    else $error("special decode wrong");
  debug_command_a: assert property (
    !rst_in [*5] ##0 debug_cmd_in |-> ##2 background_debug_active_out)
    else $error("debug not activated");
  single_pins_a: assert property (
    mode_out[1:0] == 2'b00 |-> !queue_track_enable_out
      && !low_strobe_pin_enable_out && !read_write_pin_enable_out)
    else $error("pin enable in single chip");
  read_idle_a: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data outside read");
  mode_stable_a: assert property (
    (!rst_in && !(wr_in && addr_in == 4'h0)) [*5] |=> $stable(mode_out))
    else $error("mode changed without write");
endmodule
bind operating_mode_select operating_mode_select_props
  operating_mode_select_props_i (.*);
`default_nettype wire

/* bench/strap_board.sv */
`timescale 1ns/1ps
`default_nettype none
module strap_board (
  // Control
  input wire logic mclk_in,
  input wire logic drive_in,
  input wire logic pulldown_in,
  input wire logic [2:0] code_in,
  // Straps {high, mid, low}
  output logic [2:0] straps_out
);
  logic [2:0] last_reg = 3'h0;
  always_ff @(posedge mclk_in) begin
    last_reg <= straps_out;
  end
  // Released pins wander; mid and low fall to the pull-down in reset
  always_comb begin
    straps_out = ~last_reg;
    if (pulldown_in) begin
      straps_out[1:0] = 2'b00;
    end
    if (drive_in) begin
      straps_out = code_in;
    end
  end
endmodule
`default_nettype wire

/* bench/operating_mode_select_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "opmode_consts.vh"
`define CHK(nm, ex, got) begin \
  check_count++; \
  if ((got) !== (ex)) begin \
    num_errors++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); \
  end \
end
module operating_mode_select_test;
  logic mclk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0;
  logic debug_cmd_in = 0, drive = 1;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00, rdata_out, memmap_out, rd_val;
  logic [2:0] code = 3'h0, mode_out;
  logic special_mode_out, factory_test_out, background_debug_active_out;
  logic expanded_narrow_out, expanded_wide_out, internal_visibility_out;
  logic queue_track_enable_out, low_strobe_pin_enable_out;
  logic read_write_pin_enable_out, bus_clock_stretch_out;
  logic maskable_int_enable_out, nonmaskable_interrupt_pin_enable_out;
  logic int_pins_pullup_out, mode_pins_pulldown_out;
  wire mode_strap_high_in, mode_strap_mid_in, mode_strap_low_in;
  wire [2:0] int_bits = {maskable_int_enable_out,
    nonmaskable_interrupt_pin_enable_out, int_pins_pullup_out};
  wire [2:0] pin_bits = {queue_track_enable_out, low_strobe_pin_enable_out,
    read_write_pin_enable_out};
  int num_errors = 0;
  int check_count = 0;
  // Rows by code: {special, test, debug, narrow, wide, map}
  logic [15:0] rows [8] = '{16'h1401, 16'h1202, 16'h1800, 16'h1103,
    16'h0001, 16'h0202, 16'h0800, 16'h0103};
  operating_mode_select operating_mode_select_i (.*);
  strap_board strap_board_i (.mclk_in(mclk_in), .drive_in(drive),
    .pulldown_in(mode_pins_pulldown_out), .code_in(code),
    .straps_out({mode_strap_high_in, mode_strap_mid_in, mode_strap_low_in}));
  task automatic do_reset(input logic [2:0] c);
    @(posedge mclk_in);
    code <= c;
    drive <= 1'b1;
    rst_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    #1 `CHK("pull-down", 1'b1, mode_pins_pulldown_out)
    @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    drive <= 1'b0;
    repeat (4) @(posedge mclk_in);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    forever #2.5 mclk_in = ~mclk_in;
  end
  initial begin
    for (int i = 0; i < 8; i++) begin
      do_reset(3'(i));
      `CHK("mode", 3'(i), mode_out)
      `CHK("special", rows[i][12], special_mode_out)
      `CHK("test", rows[i][11], factory_test_out)
      `CHK("debug", rows[i][10], background_debug_active_out)
      `CHK("bus", rows[i][9:8], {expanded_narrow_out, expanded_wide_out})
      `CHK("map", rows[i][7:0], memmap_out)
      `CHK("stretch", 1'b1, bus_clock_stretch_out)
      `CHK("ints", 3'b001, int_bits)
      `CHK("released", 1'b0, mode_pins_pulldown_out)
      $display("mode %0d done", i);
    end
    // Normal single chip
    do_reset(3'h4);
    wr(`OFS_PORT_E_ASSIGN, 8'h34);
    `CHK("pins", 3'b000, pin_bits)
    wr(`OFS_INT_CTRL, 8'h03);
    `CHK("ints on", 3'b110, int_bits)
    @(posedge mclk_in);
    debug_cmd_in <= 1'b1;
    @(posedge mclk_in);
    debug_cmd_in <= 1'b0;
    #1 `CHK("debug idle", 1'b0, background_debug_active_out)
    repeat (2) @(posedge mclk_in);
    #1 `CHK("debug on", 1'b1, background_debug_active_out)
    wr(`OFS_MODE, 8'hE8);
    `CHK("mode wide", 3'h7, mode_out)
    `CHK("vis", 1'b1, internal_visibility_out)
    wr(`OFS_MODE, 8'hA0);
    `CHK("mode locked", 3'h7, mode_out)
    rd(`OFS_MODE, rd_val);
    `CHK("mode read", 3'h7, rd_val[7:5])
    rd(4'hF, rd_val);
    `CHK("unmapped", 8'h00, rd_val)
    $display("normal single done");
    // Special single
    do_reset(3'h0);
    wr(`OFS_MODE, 8'h40);
    `CHK("test refused", 3'h0, mode_out)
    wr(`OFS_MODE, 8'h60);
    `CHK("special write", 3'h3, mode_out)
    $display("special done");
    end_of_test();
  end
endmodule
`default_nettype wire
